// file: rtl/_unused_guard.v
`timescale 1ns/1ps

// file: rtl/epr_consts.vh
`ifndef EPR_CONSTS_VH
`define EPR_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EPR_OFF_CTRL 12'h000
`define EPR_OFF_RES 12'h004
`define EPR_OFF_PRESET 12'h008
`define EPR_OFF_CYCLE 12'h00c
`define EPR_OFF_SYNC 12'h010
`define EPR_OFF_LIM_MIN 12'h014
`define EPR_OFF_LIM_MAX 12'h018
`define EPR_OFF_STATUS 12'h01c
`define EPR_OFF_POS 12'h020
`define EPR_OFF_CAM_BASE 12'h040
// ----------------------------------------
// Field positions
// ----------------------------------------
`define EPR_CTRL_POLL 0
`define EPR_CTRL_CYC 1
`define EPR_CTRL_SYNC 2
`define EPR_CTRL_DIR 3
`define EPR_ST_READY 0
`define EPR_ST_BUSOFF 1
`define EPR_ST_WARN 2
`define EPR_ST_ERREV 3
`define EPR_ST_NMT_LO 4
`define EPR_PV_OOR 31
// ----------------------------------------
// Reset values
// ----------------------------------------
`define EPR_RST_CTRL 4'h1
`define EPR_RST_RES 17'h10000
`define EPR_RST_CYCLE 16'h0063
`define EPR_RST_SYNC 8'h01
`define EPR_RST_LIM_MIN 31'h00000000
`define EPR_RST_LIM_MAX 31'h7fffffff
// ----------------------------------------
// Network states and LED patterns
// ----------------------------------------
`define EPR_NMT_PREOP 2'h0
`define EPR_NMT_STOP 2'h1
`define EPR_NMT_OPER 2'h2
`define EPR_PAT_OFF 3'h0
`define EPR_PAT_ON 3'h1
`define EPR_PAT_FLICK 3'h2
`define EPR_PAT_BLINK 3'h3
`define EPR_PAT_SINGLE 3'h4
`define EPR_PAT_DOUBLE 3'h5
// ----------------------------------------
// Timing
// ----------------------------------------
`define EPR_CLK_HZ 10000000
`define EPR_TICK_MS 1
`define EPR_TICK_CYCLES (`EPR_CLK_HZ / 1000 * `EPR_TICK_MS)
`define EPR_AVAIL_MS 250
`define EPR_LED_STEP_MS 50
`define EPR_LED_PHASES 24
`endif

// file: rtl/epr_led.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// LED pattern generator
// ----------------------------------------
`include "epr_consts.vh"
module epr_led (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_ms_tick,
  input wire [2:0] i_run_pat,
  input wire [2:0] i_err_pat,
  output reg o_run_led,
  output reg o_err_led
);
  reg [5:0] step_reg;
  reg [4:0] phase_reg;
  wire step_tick;

  assign step_tick = i_ms_tick && (step_reg == `EPR_LED_STEP_MS - 1);

  // One phase is 50 ms; a full pattern spans 24 phases
  function pat_on;
    input [2:0] pat;
    input [4:0] ph;
    begin
      case (pat)
        `EPR_PAT_ON: pat_on = 1'b1;
        `EPR_PAT_FLICK: pat_on = ph[0];
        `EPR_PAT_BLINK: pat_on = ph[2];
        `EPR_PAT_SINGLE: pat_on = (ph < 5'h04);
        `EPR_PAT_DOUBLE: pat_on = (ph < 5'h04) || ((ph >= 5'h08) && (ph < 5'h0c));
        default: pat_on = 1'b0;
      endcase
    end
  endfunction

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_reg <= 6'h00;
      phase_reg <= 5'h00;
      o_run_led <= 1'b0;
      o_err_led <= 1'b0;
    end else begin
      if (step_tick) begin
        step_reg <= 6'h00;
        phase_reg <= (phase_reg == `EPR_LED_PHASES - 1) ? 5'h00 : phase_reg + 5'h01;
      end else if (i_ms_tick) begin
        step_reg <= step_reg + 6'h01;
      end
      o_run_led <= pat_on(i_run_pat, phase_reg);
      o_err_led <= pat_on(i_err_pat, phase_reg);
    end
  end
endmodule // epr_led
`default_nettype wire

// file: rtl/epr_top.v
`timescale 1ns/1ps
`default_nettype none
`include "epr_consts.vh"
module epr_top #(
  parameter MS_CYCLES = `EPR_TICK_CYCLES,
  parameter READY_MS = `EPR_AVAIL_MS - 1,
  parameter NUM_CAMS = 8
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // Raw shaft position
  input wire [15:0] i_raw_angle,
  input wire [14:0] i_raw_turns,
  // Network side events and state
  input wire i_rtr_rx,
  input wire i_sync_rx,
  input wire [1:0] i_nmt_state,
  input wire i_boot_sent,
  input wire i_abd_active,
  input wire i_err_warn,
  input wire i_err_event,
  input wire i_bus_off,
  // Frame request to the CAN controller
  output reg o_tx_strobe,
  output reg o_tx_same_id,
  output reg [31:0] o_tx_value,
  output reg o_ready,
  output reg [NUM_CAMS-1:0] o_cam,
  output wire o_run_led,
  output wire o_err_led
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function in_win;
    input [30:0] v;
    input [30:0] lo;
    input [30:0] hi;
    begin
      in_win = (v >= lo) && (v <= hi);
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [3:0] ctrl_reg;
  reg [16:0] res_reg;
  reg [30:0] offset_reg;
  reg [15:0] cycle_reg;
  reg [7:0] sync_cfg_reg;
  reg [30:0] lim_min_reg;
  reg [30:0] lim_max_reg;
  reg err_ev_reg;
  reg [30:0] cam_lo_reg [0:NUM_CAMS-1];
  reg [30:0] cam_hi_reg [0:NUM_CAMS-1];
  reg [13:0] tick_cnt_reg;
  reg ms_tick_reg;
  reg [15:0] cyc_cnt_reg;
  reg [7:0] sync_cnt_reg;
  reg [8:0] ready_cnt_reg;
  reg [31:0] pv_reg;
  reg [2:0] run_pat_reg;
  reg [2:0] err_pat_reg;

  wire setup_ph;
  wire wr_en;
  wire cam_sel;
  wire [2:0] cam_idx;
  wire [31:0] turn_part;
  wire [32:0] angle_prod;
  wire [30:0] scaled;
  wire [30:0] dir_pos;
  wire [30:0] final_pos;
  wire out_of_range;
  wire [31:0] pv_now;
  wire tx_allowed;
  wire poll_fire;
  wire cyc_fire;
  wire sync_fire;
  integer i;
  integer j;

  // ----------------------------------------
  // Position path
  // ----------------------------------------
  // Steps per revolution scale both the turn count and the angle fraction
  assign turn_part = (i_raw_turns * res_reg[15:0]) + ({1'b0, i_raw_turns, 16'h0000} & {32{res_reg[16]}});
  assign angle_prod = i_raw_angle * res_reg;
  assign scaled = turn_part[30:0] + {14'h0000, angle_prod[32:16]};
  // Complement counts down by taking the two's complement modulo 2^31
  assign dir_pos = ctrl_reg[`EPR_CTRL_DIR] ? (31'h00000000 - scaled) : scaled;
  assign final_pos = dir_pos + offset_reg;
  assign out_of_range = !in_win(final_pos, lim_min_reg, lim_max_reg);
  assign pv_now = {out_of_range, final_pos};

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign setup_ph = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite;
  assign cam_sel = (i_paddr[11:6] == 6'h01) && (i_paddr[5:4] < NUM_CAMS / 2);
  assign cam_idx = i_paddr[5:3];

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      // Zero wait states: the answer is prepared during the setup cycle
      o_pready <= setup_ph;
      if (setup_ph) begin
        o_pslverr <= 1'b0;
        o_prdata <= 32'h00000000;
        if (i_paddr[1:0] != 2'h0) begin
          o_pslverr <= 1'b1;
        end else if (cam_sel) begin
          o_prdata <= {1'b0, i_paddr[2] ? cam_hi_reg[cam_idx] : cam_lo_reg[cam_idx]};
        end else begin
          case (i_paddr)
            `EPR_OFF_CTRL: o_prdata <= {28'h0000000, ctrl_reg};
            `EPR_OFF_RES: o_prdata <= {15'h0000, res_reg};
            `EPR_OFF_PRESET: o_prdata <= {1'b0, final_pos};
            `EPR_OFF_CYCLE: o_prdata <= {16'h0000, cycle_reg};
            `EPR_OFF_SYNC: o_prdata <= {24'h000000, sync_cfg_reg};
            `EPR_OFF_LIM_MIN: o_prdata <= {1'b0, lim_min_reg};
            `EPR_OFF_LIM_MAX: o_prdata <= {1'b0, lim_max_reg};
            `EPR_OFF_STATUS: o_prdata <= {26'h0000000, i_nmt_state, err_ev_reg, i_err_warn, i_bus_off, o_ready};
            `EPR_OFF_POS: o_prdata <= pv_reg;
            default: o_pslverr <= 1'b1;
          endcase
        end
      end
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= `EPR_RST_CTRL;
      res_reg <= `EPR_RST_RES;
      offset_reg <= 31'h00000000;
      cycle_reg <= `EPR_RST_CYCLE;
      sync_cfg_reg <= `EPR_RST_SYNC;
      lim_min_reg <= `EPR_RST_LIM_MIN;
      lim_max_reg <= `EPR_RST_LIM_MAX;
      for (i = 0; i < NUM_CAMS; i = i + 1) begin
        cam_lo_reg[i] <= 31'h00000000;
        cam_hi_reg[i] <= 31'h00000000;
      end
    end else if (wr_en && !o_pslverr) begin
      if (cam_sel) begin
        if (i_paddr[2]) begin
          cam_hi_reg[cam_idx] <= i_pwdata[30:0];
        end else begin
          cam_lo_reg[cam_idx] <= i_pwdata[30:0];
        end
      end else begin
        case (i_paddr)
          `EPR_OFF_CTRL: ctrl_reg <= i_pwdata[3:0];
          `EPR_OFF_RES: res_reg <= (i_pwdata[16:0] == 17'h00000) ? 17'h00001 : i_pwdata[16:0];
          // Offset chosen so the present shaft position reads as the preset
          `EPR_OFF_PRESET: offset_reg <= i_pwdata[30:0] - dir_pos;
          `EPR_OFF_CYCLE: cycle_reg <= i_pwdata[15:0];
          `EPR_OFF_SYNC: sync_cfg_reg <= i_pwdata[7:0];
          `EPR_OFF_LIM_MIN: lim_min_reg <= i_pwdata[30:0];
          `EPR_OFF_LIM_MAX: lim_max_reg <= i_pwdata[30:0];
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Millisecond tick and availability
  // ----------------------------------------
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_reg <= 14'h0000;
      ms_tick_reg <= 1'b0;
      ready_cnt_reg <= 9'h000;
      o_ready <= 1'b0;
    end else begin
      ms_tick_reg <= (tick_cnt_reg == MS_CYCLES - 1);
      tick_cnt_reg <= (tick_cnt_reg == MS_CYCLES - 1) ? 14'h0000 : tick_cnt_reg + 14'h0001;
      if (ms_tick_reg && !o_ready) begin
        ready_cnt_reg <= ready_cnt_reg + 9'h001;
        o_ready <= (ready_cnt_reg == READY_MS - 1);
      end
    end
  end

  // ----------------------------------------
  // Transmission triggers
  // ----------------------------------------
  // Bus-off stops all traffic until the controller recovers
  assign tx_allowed = o_ready && !i_bus_off;
  assign poll_fire = tx_allowed && ctrl_reg[`EPR_CTRL_POLL] && i_rtr_rx;
  assign cyc_fire = tx_allowed && ctrl_reg[`EPR_CTRL_CYC] && ms_tick_reg && (cyc_cnt_reg == cycle_reg);
  // Counter value 0 behaves as 1 so sync mode never locks up
  assign sync_fire = tx_allowed && ctrl_reg[`EPR_CTRL_SYNC] && i_sync_rx &&
                     (sync_cnt_reg + 8'h01 >= sync_cfg_reg);

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_cnt_reg <= 16'h0000;
      sync_cnt_reg <= 8'h00;
    end else begin
      if (!ctrl_reg[`EPR_CTRL_CYC]) begin
        cyc_cnt_reg <= 16'h0000;
      end else if (ms_tick_reg) begin
        cyc_cnt_reg <= (cyc_cnt_reg >= cycle_reg) ? 16'h0000 : cyc_cnt_reg + 16'h0001;
      end
      if (!ctrl_reg[`EPR_CTRL_SYNC]) begin
        sync_cnt_reg <= 8'h00;
      end else if (i_sync_rx && tx_allowed) begin
        sync_cnt_reg <= sync_fire ? 8'h00 : sync_cnt_reg + 8'h01;
      end
    end
  end

  // Value is sampled in the same cycle the trigger arrives; no offset delay
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pv_reg <= 32'h00000000;
      o_tx_strobe <= 1'b0;
      o_tx_same_id <= 1'b0;
      o_tx_value <= 32'h00000000;
      o_cam <= {NUM_CAMS{1'b0}};
    end else begin
      pv_reg <= pv_now;
      o_tx_strobe <= poll_fire || cyc_fire || sync_fire;
      o_tx_same_id <= poll_fire;
      if (poll_fire || cyc_fire || sync_fire) begin
        o_tx_value <= pv_now;
      end
      for (j = 0; j < NUM_CAMS; j = j + 1) begin
        o_cam[j] <= in_win(final_pos, cam_lo_reg[j], cam_hi_reg[j]);
      end
    end
  end

  // ----------------------------------------
  // Indicators
  // ----------------------------------------
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_ev_reg <= 1'b0;
      run_pat_reg <= `EPR_PAT_OFF;
      err_pat_reg <= `EPR_PAT_OFF;
    end else begin
      // A new event wins over a software clear in the same cycle
      if (i_err_event) begin
        err_ev_reg <= 1'b1;
      end else if (wr_en && (i_paddr == `EPR_OFF_STATUS) && i_pwdata[`EPR_ST_ERREV]) begin
        err_ev_reg <= 1'b0;
      end
      if (!o_ready) begin
        run_pat_reg <= `EPR_PAT_OFF;
      end else begin
        case (i_nmt_state)
          `EPR_NMT_PREOP: run_pat_reg <= i_boot_sent ? `EPR_PAT_BLINK : `EPR_PAT_OFF;
          `EPR_NMT_STOP: run_pat_reg <= `EPR_PAT_SINGLE;
          `EPR_NMT_OPER: run_pat_reg <= `EPR_PAT_ON;
          default: run_pat_reg <= `EPR_PAT_OFF;
        endcase
      end
      // Most severe condition owns the red LED
      if (i_bus_off) begin
        err_pat_reg <= `EPR_PAT_ON;
      end else if (err_ev_reg) begin
        err_pat_reg <= `EPR_PAT_DOUBLE;
      end else if (i_err_warn) begin
        err_pat_reg <= `EPR_PAT_SINGLE;
      end else if (i_abd_active) begin
        err_pat_reg <= `EPR_PAT_FLICK;
      end else begin
        err_pat_reg <= `EPR_PAT_OFF;
      end
    end
  end

  epr_led u_led (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ms_tick(ms_tick_reg),
    .i_run_pat(run_pat_reg),
    .i_err_pat(err_pat_reg),
    .o_run_led(o_run_led),
    .o_err_led(o_err_led)
  );
endmodule // epr_top
`default_nettype wire

// file: verif/encoder_position_reporting_can_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "epr_consts.vh"
// ----
// Bench
// ----
module encoder_position_reporting_can_test;
  localparam int MS = 5;
  localparam int PAT = 1200 * MS;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lerr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, value;
  logic [15:0] angle = 16'h4000;
  logic [14:0] turns = 15'h0003;
  logic [1:0] nmt = 2'h0;
  logic boot = 1'b1, abd = 1'b0, warn = 1'b0, evt = 1'b0, busoff = 1'b0;
  logic pready, pslverr, rtr, sync, strobe, same_id, ready, run_led, err_led;
  logic [7:0] cam;
  int err_total = 0, checked = 0;
  epr_top #(.MS_CYCLES(MS), .READY_MS(3), .NUM_CAMS(8)) dut_u (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_raw_angle(angle), .i_raw_turns(turns), .i_rtr_rx(rtr), .i_sync_rx(sync), .i_nmt_state(nmt),
    .i_boot_sent(boot), .i_abd_active(abd), .i_err_warn(warn), .i_err_event(evt), .i_bus_off(busoff),
    .o_tx_strobe(strobe), .o_tx_same_id(same_id), .o_tx_value(value), .o_ready(ready), .o_cam(cam),
    .o_run_led(run_led), .o_err_led(err_led));
  epr_host_model host_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_tx_strobe(strobe), .o_rtr_rx(rtr),
    .o_sync_rx(sync));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic wrap_up();
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask
  // Slack for the registered position and cam outputs before looking at results
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  task automatic poll(input logic [31:0] exp_v, input logic exp_tx);
    host_u.pulse(1'b1);
    #1;
    chk("poll strobe", strobe, exp_tx);
    if (exp_tx) begin
      chk("poll id", same_id, 32'h1);
      chk("poll value", value, exp_v);
    end
  endtask
  task automatic t_ready();
    int n;
    poll(32'h0, 1'b0);
    n = 0;
    while (ready !== 1'b1 && n < 5 * MS) begin
      @(posedge clk);
      n++;
    end
    chk("ready", ready, 32'h1);
    if (ready !== 1'b1) wrap_up();
  endtask
  task automatic t_regs();
    logic [11:0] a[6] = '{`EPR_OFF_CTRL, `EPR_OFF_RES, `EPR_OFF_CYCLE, `EPR_OFF_SYNC,
      `EPR_OFF_LIM_MIN, `EPR_OFF_LIM_MAX};
    logic [31:0] x[6] = '{32'h1, 32'h10000, 32'h63, 32'h1, 32'h0, 32'h7fffffff};
    logic [31:0] q;
    for (int i = 0; i < 6; i++) rdc("reset value", a[i], x[i]);
    apb(1'b0, 12'h024, 32'h0, q);
    chk("unmapped", {q[30:0], lerr}, 32'h1);
    wr(`EPR_OFF_CYCLE, 32'hffff);
    rdc("longest cycle", `EPR_OFF_CYCLE, 32'hffff);
  endtask
  task automatic t_scale();
    wr(`EPR_OFF_RES, 32'h168);
    poll(32'h492, 1'b1);
    wr(`EPR_OFF_CTRL, 32'h9);
    poll(32'h7ffffb6e, 1'b1);
    wr(`EPR_OFF_CTRL, 32'h1);
  endtask
  task automatic t_preset();
    wr(`EPR_OFF_PRESET, 32'h3e8);
    settle();
    rdc("preset", `EPR_OFF_POS, 32'h3e8);
    turns <= 15'h0004;
    wr(`EPR_OFF_LIM_MIN, 32'h384);
    wr(`EPR_OFF_LIM_MAX, 32'h3e8);
    settle();
    rdc("above max", `EPR_OFF_POS, 32'h80000550);
    turns <= 15'h0003;
    settle();
    rdc("at max", `EPR_OFF_POS, 32'h3e8);
    wr(`EPR_OFF_LIM_MAX, 32'h7fffffff);
    wr(`EPR_OFF_PRESET, 32'h492);
  endtask
  task automatic t_cams();
    for (int i = 0; i < 8; i++) begin
      wr(`EPR_OFF_CAM_BASE + 12'(8 * i), 32'h490 + 32'(i));
      wr(`EPR_OFF_CAM_BASE + 12'(8 * i + 4), 32'h497);
    end
    settle();
    chk("cams low edge", cam, 32'h07);
    angle <= 16'h438f;
    settle();
    chk("cams high edge", cam, 32'hff);
    angle <= 16'h4445;
    settle();
    chk("cams beyond", cam, 32'h00);
    angle <= 16'h4000;
  endtask
  task automatic t_sync();
    wr(`EPR_OFF_SYNC, 32'h3);
    wr(`EPR_OFF_CTRL, 32'h4);
    settle();
    for (int k = 0; k < 6; k++) begin
      host_u.pulse(1'b0);
      #1;
      chk("sync strobe", strobe, 32'(k % 3 == 2));
      if (k % 3 == 2) chk("sync value", {value[30:0], same_id}, 32'h924);
    end
    poll(32'h0, 1'b0);
  endtask
  task automatic t_cyclic();
    int f;
    logic [31:0] per[2] = '{32'h0, 32'h3};
    int n[2] = '{20, 5};
    for (int i = 0; i < 2; i++) begin
      wr(`EPR_OFF_CYCLE, per[i]);
      wr(`EPR_OFF_CTRL, 32'h2);
      f = host_u.frames;
      repeat (100) @(posedge clk);
      f = host_u.frames - f;
      chk("cyclic count", 32'(f >= n[i] - 1 && f <= n[i] + 1), 32'h1);
    end
    wr(`EPR_OFF_CTRL, 32'h1);
  endtask
  // One full pattern period, so the count does not depend on phase
  task automatic leds(input int exp_run, input int exp_err);
    int r;
    int e;
    r = 0;
    e = 0;
    repeat (4) @(posedge clk);
    repeat (PAT) begin
      @(posedge clk);
      r += (run_led === 1'b1);
      e += (err_led === 1'b1);
    end
    if (exp_run >= 0) chk("run led", r, exp_run);
    chk("red led", e, exp_err);
  endtask
  task automatic t_leds();
    nmt <= `EPR_NMT_OPER;
    leds(PAT, 0);
    nmt <= `EPR_NMT_STOP;
    abd <= 1'b1;
    leds(PAT / 6, PAT / 2);
    nmt <= `EPR_NMT_PREOP;
    warn <= 1'b1;
    leds(PAT / 2, PAT / 6);
    nmt <= `EPR_NMT_OPER;
    evt <= 1'b1;
    @(posedge clk);
    evt <= 1'b0;
    leds(PAT, PAT / 3);
    rdc("status", `EPR_OFF_STATUS, 32'h2d);
    wr(`EPR_OFF_STATUS, 32'h8);
    rdc("status cleared", `EPR_OFF_STATUS, 32'h25);
    busoff <= 1'b1;
    leds(-1, PAT);
    poll(32'h0, 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_ready();
    t_regs();
    t_scale();
    t_preset();
    t_cams();
    t_sync();
    t_cyclic();
    t_leds();
    wrap_up();
  end
endmodule // encoder_position_reporting_can_test
`default_nettype wire

// file: verif/epr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Host on the bus
// ----
module epr_host_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_tx_strobe,
  output logic o_rtr_rx,
  output logic o_sync_rx
);
  int frames;
  initial begin
    o_rtr_rx = 1'b0;
    o_sync_rx = 1'b0;
  end
  // Lone node here, so sync answers never contend for the bus
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frames <= 0;
    end else if (i_tx_strobe) begin
      frames <= frames + 1;
    end
  end
  task automatic pulse(input logic rtr);
    @(posedge i_ref_clk);
    if (rtr) begin
      o_rtr_rx <= 1'b1;
    end else begin
      o_sync_rx <= 1'b1;
    end
    @(posedge i_ref_clk);
    o_rtr_rx <= 1'b0;
    o_sync_rx <= 1'b0;
  endtask
endmodule // epr_host_model
`default_nettype wire

// file: verif/epr_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "epr_consts.vh"
// ----
// Port checker
// ----
module epr_top_chk #(
  parameter int MS_CYCLES = 10,
  parameter int READY_MS = 3
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_rtr_rx,
  input wire logic [1:0] i_nmt_state,
  input wire logic i_bus_off,
  input wire logic o_tx_strobe,
  input wire logic o_tx_same_id,
  input wire logic [31:0] o_tx_value,
  input wire logic o_ready,
  input wire logic o_run_led,
  input wire logic o_err_led
);
  // Slack of two ms ticks: the LED path may follow the tick
  localparam int SETTLE = 2 * MS_CYCLES + 2;
  localparam int READY_MAX = (READY_MS + 2) * MS_CYCLES;
  int up_cnt;
  int off_cnt;
  int run_cnt;
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_cnt <= 0;
      off_cnt <= 0;
      run_cnt <= 0;
    end else begin
      up_cnt <= (up_cnt < 200000) ? up_cnt + 1 : up_cnt;
      off_cnt <= i_bus_off ? off_cnt + 1 : 0;
      run_cnt <= (o_ready && i_nmt_state == `EPR_NMT_OPER) ? run_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_tx_blocked;
    (!o_ready || i_bus_off) ##1 o_tx_strobe;
  endsequence
  sequence s_tag_unasked;
    !i_rtr_rx ##1 o_tx_same_id;
  endsequence
  AST_TX_GATED: assert property (not s_tx_blocked)
    else $error("frame sent while not ready or bus-off");
  AST_SAME_ID: assert property (not s_tag_unasked)
    else $error("request identifier used without a request");
  AST_VALUE_HOLDS: assert property (!o_tx_strobe |-> $stable(o_tx_value))
    else $error("frame value moved without a frame");
  AST_RED_BUSOFF: assert property (off_cnt >= SETTLE |-> o_err_led)
    else $error("red LED not steady in bus-off");
  AST_RUN_DARK: assert property (!o_ready && !$past(o_ready) |-> !o_run_led)
    else $error("green LED lit before availability");
  AST_RUN_OPER: assert property (run_cnt >= SETTLE |-> o_run_led)
    else $error("green LED not on in operational state");
  AST_READY_BY: assert property (up_cnt >= READY_MAX |-> o_ready)
    else $error("device not available in time");
  AST_READY_KEEP: assert property (o_ready |=> o_ready)
    else $error("availability dropped");
endmodule // epr_top_chk
bind epr_top epr_top_chk #(.MS_CYCLES(MS_CYCLES), .READY_MS(READY_MS)) chk_u (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_rtr_rx(i_rtr_rx), .i_nmt_state(i_nmt_state),
  .i_bus_off(i_bus_off), .o_tx_strobe(o_tx_strobe), .o_tx_same_id(o_tx_same_id),
  .o_tx_value(o_tx_value), .o_ready(o_ready), .o_run_led(o_run_led), .o_err_led(o_err_led));
`default_nettype wire
